// ===== rtl/flgctl_pkg.sv
// constants and types shared by the flags register block
package flgctl_pkg;
    localparam int unsigned FLAGS_W   = 32;
    localparam int unsigned FLAGS64_W = 64;
    localparam int unsigned IDX_W     = 32;
    // flag bit positions in the flags word
    localparam int unsigned BIT_CARRY  = 0;
    localparam int unsigned BIT_PARITY = 2;
    localparam int unsigned BIT_ADJUST = 4;
    localparam int unsigned BIT_ZERO   = 6;
    localparam int unsigned BIT_SIGN   = 7;
    localparam int unsigned BIT_IE     = 9;
    localparam int unsigned BIT_DIR    = 10;
    localparam int unsigned BIT_IO_PRIVILEGE_LEVEL_LO = 12;
    localparam int unsigned BIT_IO_PRIVILEGE_LEVEL_HI = 13;
    localparam int unsigned BIT_RESUME = 16;
    localparam int unsigned BIT_V86    = 17;
    localparam int unsigned BIT_ALIGN  = 18;
    localparam int unsigned BIT_PROBE  = 21;
    // write masks for the pop forms and masks for the push forms
    localparam logic [31:0] POP_WORD_MASK  = 32'h0000_0dd5;
    localparam logic [31:0] POP_DWORD_XTRA = 32'h0024_0000;
    localparam logic [31:0] IO_PRIVILEGE_LEVEL_MASK      = 32'h0000_3000;
    localparam logic [31:0] IE_MASK        = 32'h0000_0200;
    localparam logic [31:0] PUSH_CLR_MASK  = 32'h0003_0000;
    localparam logic [31:0] WORD_MASK      = 32'h0000_ffff;
    // bit 1 of the flags word always reads as one
    localparam logic [31:0] FLAGS_RESET    = 32'h0000_0002;
    localparam logic [31:0] FIXED_ONES     = 32'h0000_0002;
    localparam logic [1:0]  PRIV_TOP       = 2'h0;
    localparam logic [7:0]  ACCUM_KEEP     = 8'h2a;

    // operation codes from the execution pipeline
    typedef enum logic [3:0] {
        FLGCTL_NOP        = 4'h0,
        FLGCTL_SET_CARRY  = 4'h1,
        FLGCTL_CLR_CARRY  = 4'h2,
        FLGCTL_INV_CARRY  = 4'h3,
        FLGCTL_SET_DIR    = 4'h4,
        FLGCTL_CLR_DIR    = 4'h5,
        FLGCTL_TO_ACCUM   = 4'h6,
        FLGCTL_FROM_ACCUM = 4'h7,
        FLGCTL_PUSH_WORD  = 4'h8,
        FLGCTL_PUSH_DWORD = 4'h9,
        FLGCTL_POP_WORD   = 4'ha,
        FLGCTL_POP_DWORD  = 4'hb,
        FLGCTL_SET_IE     = 4'hc,
        FLGCTL_CLR_IE     = 4'hd,
        FLGCTL_STRING_STEP = 4'he
    } flgctl_op_e;

    // answer status of one operation
    typedef enum logic [1:0] {
        FLGCTL_ST_IDLE = 2'h0,
        FLGCTL_ST_DONE = 2'h1,
        FLGCTL_ST_FAULT = 2'h3
    } flgctl_st_e;
endpackage

// ===== rtl/flgctl_idx_step.sv
// one index register stepped by the direction flag
`timescale 1ns/1ps
`default_nettype none
module flgctl_idx_step
    import flgctl_pkg::*;
#(
    parameter int unsigned W = IDX_W
)
(
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         step_i,
    input  wire logic         dir_i,
    input  wire logic [3:0]   size_i,
    output logic      [W-1:0] val_o
);
    typedef struct packed {
        logic [W-1:0] val;
    } flgctl_idx_s;

    flgctl_idx_s cur;
    flgctl_idx_s next_cur;

    // refuse widths too narrow for an element step
    if (W < 8)
    begin : g_bad_width
        $error("flgctl_idx_step: width too small");
    end

    // load wins over step; step goes up or down by element size
    always_comb
    begin
        next_cur = cur;
        if (load_i)
            next_cur.val = load_val_i;
        else if (step_i && !dir_i)
            next_cur.val = cur.val + W'(size_i);
        else if (step_i && dir_i)
            next_cur.val = cur.val - W'(size_i);
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign val_o = cur.val;
endmodule
`default_nettype wire

// ===== rtl/flgctl_top.sv
// flags register with flag-control operation logic
// Contract
// - set, clear and invert carry operations touch only carry_flag
// - set and clear direction operations write direction_flag only
// - string step raises index registers when direction clear, else lowers
// - flags to accum copies sign, zero, adjust, parity, carry to 7,6,4,2,0
// - flags to accum keeps accum bits 5,3,1 and leaves flags unchanged
// - accum to flags loads the five status flags from bits 7,6,4,2,0
// - word push places only the low 16 flag bits on the stack
// - dword push sends all 32 bits with resume and v86 cleared
// - word pop updates only bits 11,10,8,7,6,4,2,0
// - pop updates io privilege bits 13:12 only at privilege level zero
// - pop updates interrupt enable only when io level >= current level
// - dword pop also updates alignment check bit 18 and probe bit 21
// - dword pop uses the same privilege conditions as word pop
// - maskable interrupts pass only while interrupt enable is set
// - interrupt enable set or clear allowed depending on mode and privilege; code ignores mode and checks io level >= current level only
// - in 64-bit mode accum transfers need the feature bit set
// - in 64-bit mode dword push sends 64 bits, resume and v86 cleared
// - in 64-bit mode dword pop loads low 32 bits, upper zero
`timescale 1ns/1ps
`default_nettype none
module flgctl_top
    import flgctl_pkg::*;
#(
    parameter int unsigned IDX_WIDTH = IDX_W
)
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    // operation request from the execution pipeline
    input  wire logic                 op_valid_i,
    input  wire logic [3:0]           op_code_i,
    input  wire logic [7:0]           accum_high_byte_i,
    input  wire logic [63:0]          pop_data_i,
    input  wire logic [1:0]           current_privilege_level_i,
    input  wire logic                 mode64_i,
    input  wire logic                 v86_mode_i,
    input  wire logic                 flags_to_accum_op_feature_i,
    input  wire logic [3:0]           elem_size_i,
    input  wire logic                 idx_load_i,
    input  wire logic [IDX_WIDTH-1:0] src_load_i,
    input  wire logic [IDX_WIDTH-1:0] dst_load_i,
    input  wire logic                 maskable_irq_pin_i,
    // results
    output logic      [31:0]          flags_word32_o,
    output logic      [7:0]           accum_high_byte_o,
    output logic                      accum_we_o,
    output logic      [63:0]          push_data_o,
    output logic      [1:0]           push_size_o,
    output logic                      push_valid_o,
    output logic                      op_done_o,
    output logic                      op_fault_o,
    output logic                      irq_take_o,
    output logic      [IDX_WIDTH-1:0] source_index_reg_o,
    output logic      [IDX_WIDTH-1:0] dest_index_reg_o
);
    // state of the block apart from the two index registers
    typedef struct packed {
        logic [31:0] flags;
        logic [7:0]  accum;
        logic        accum_we;
        logic [63:0] push_data;
        logic [1:0]  push_size;
        logic        push_valid;
        flgctl_st_e  status;
        logic        done;
        logic        fault;
        logic        irq_take;
    } flgctl_state_s;

    flgctl_state_s cur;
    flgctl_state_s next_cur;

    logic [IDX_WIDTH-1:0] src_val;
    logic [IDX_WIDTH-1:0] dst_val;
    logic                 step_req;
    logic                 io_ge_cpl;
    logic                 ie_op_ok;
    logic [31:0]          pop_mask;
    logic [31:0]          push_image;

    // refuse index widths the step logic cannot serve
    if (IDX_WIDTH < 16 || IDX_WIDTH > 64)
    begin : g_bad_idx_width
        $error("flgctl_top: IDX_WIDTH out of range");
    end

    // io level numerically at or above current level
    assign io_ge_cpl = cur.flags[BIT_IO_PRIVILEGE_LEVEL_HI:BIT_IO_PRIVILEGE_LEVEL_LO]
                       >= current_privilege_level_i;
    // interrupt enable ops allowed when io level covers the caller,
    // refused in every mode when it does not; v86_mode_i is not used
    assign ie_op_ok = io_ge_cpl;
    assign step_req = op_valid_i
                      && (flgctl_op_e'(op_code_i) == FLGCTL_STRING_STEP);

    // pop write mask from privilege and form
    always_comb
    begin
        pop_mask = POP_WORD_MASK;
        if (flgctl_op_e'(op_code_i) == FLGCTL_POP_DWORD)
            pop_mask = pop_mask | POP_DWORD_XTRA;
        if (current_privilege_level_i == PRIV_TOP)
            pop_mask = pop_mask | IO_PRIVILEGE_LEVEL_MASK;
        if (io_ge_cpl)
            pop_mask = pop_mask | IE_MASK;
    end

    // pushed image with resume and v86 read as clear
    assign push_image = cur.flags & ~PUSH_CLR_MASK;

    // next state; flags not named by an op keep their value
    always_comb
    begin
        next_cur = cur;
        next_cur.accum_we   = 1'b0;
        next_cur.push_valid = 1'b0;
        next_cur.status     = FLGCTL_ST_IDLE;
        // masked interrupt request
        next_cur.irq_take = maskable_irq_pin_i && cur.flags[BIT_IE];
        if (op_valid_i)
        begin
            next_cur.status = FLGCTL_ST_DONE;
            case (flgctl_op_e'(op_code_i))
                FLGCTL_SET_CARRY:
                    next_cur.flags[BIT_CARRY] = 1'b1;
                FLGCTL_CLR_CARRY:
                    next_cur.flags[BIT_CARRY] = 1'b0;
                FLGCTL_INV_CARRY:
                    next_cur.flags[BIT_CARRY] = ~cur.flags[BIT_CARRY];
                FLGCTL_SET_DIR:
                    next_cur.flags[BIT_DIR] = 1'b1;
                FLGCTL_CLR_DIR:
                    next_cur.flags[BIT_DIR] = 1'b0;
                FLGCTL_TO_ACCUM:
                begin
                    if (mode64_i && !flags_to_accum_op_feature_i)
                        next_cur.status = FLGCTL_ST_FAULT;
                    else
                    begin
                        // keep bits 5,3,1 of the accumulator byte
                        next_cur.accum = (accum_high_byte_i & ACCUM_KEEP)
                            | {cur.flags[BIT_SIGN], cur.flags[BIT_ZERO],
                               1'b0, cur.flags[BIT_ADJUST], 1'b0,
                               cur.flags[BIT_PARITY], 1'b0,
                               cur.flags[BIT_CARRY]};
                        next_cur.accum_we = 1'b1;
                    end
                end
                FLGCTL_FROM_ACCUM:
                begin
                    if (mode64_i && !flags_to_accum_op_feature_i)
                        next_cur.status = FLGCTL_ST_FAULT;
                    else
                    begin
                        next_cur.flags[BIT_SIGN]   = accum_high_byte_i[7];
                        next_cur.flags[BIT_ZERO]   = accum_high_byte_i[6];
                        next_cur.flags[BIT_ADJUST] = accum_high_byte_i[4];
                        next_cur.flags[BIT_PARITY] = accum_high_byte_i[2];
                        next_cur.flags[BIT_CARRY]  = accum_high_byte_i[0];
                    end
                end
                FLGCTL_PUSH_WORD:
                begin
                    next_cur.push_data  = {32'h0000_0000,
                                           cur.flags & WORD_MASK};
                    next_cur.push_size  = 2'h0;
                    next_cur.push_valid = 1'b1;
                end
                FLGCTL_PUSH_DWORD:
                begin
                    next_cur.push_data  = {32'h0000_0000, push_image};
                    next_cur.push_size  = mode64_i ? 2'h2 : 2'h1;
                    next_cur.push_valid = 1'b1;
                end
                FLGCTL_POP_WORD, FLGCTL_POP_DWORD:
                    // low 32 bits only; the upper half of a 64-bit pop
                    // is dropped, which zero-extends the 64-bit view
                    next_cur.flags = (cur.flags & ~pop_mask)
                        | (pop_data_i[31:0] & pop_mask)
                        | FIXED_ONES;
                FLGCTL_SET_IE:
                begin
                    if (ie_op_ok)
                        next_cur.flags[BIT_IE] = 1'b1;
                    else
                        next_cur.status = FLGCTL_ST_FAULT;
                end
                FLGCTL_CLR_IE:
                begin
                    if (ie_op_ok)
                        next_cur.flags[BIT_IE] = 1'b0;
                    else
                        next_cur.status = FLGCTL_ST_FAULT;
                end
                FLGCTL_STRING_STEP:
                    next_cur.status = FLGCTL_ST_DONE;
                default:
                    next_cur.status = FLGCTL_ST_FAULT;
            endcase
        end
        // answer pulses kept in flops so the ports leave straight from them
        next_cur.done  = next_cur.status == FLGCTL_ST_DONE;
        next_cur.fault = next_cur.status == FLGCTL_ST_FAULT;
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur            <= '0;
            cur.flags      <= FLAGS_RESET;
            cur.status     <= FLGCTL_ST_IDLE;
        end
        else
            cur <= next_cur;
    end

    // source index stepped by direction flag
    flgctl_idx_step #(
        .W (IDX_WIDTH)
    ) u_src (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .load_i     (idx_load_i),
        .load_val_i (src_load_i),
        .step_i     (step_req),
        .dir_i      (cur.flags[BIT_DIR]),
        .size_i     (elem_size_i),
        .val_o      (src_val)
    );

    // destination index stepped by direction flag
    flgctl_idx_step #(
        .W (IDX_WIDTH)
    ) u_dst (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .load_i     (idx_load_i),
        .load_val_i (dst_load_i),
        .step_i     (step_req),
        .dir_i      (cur.flags[BIT_DIR]),
        .size_i     (elem_size_i),
        .val_o      (dst_val)
    );

    // outputs straight from flip-flops
    assign flags_word32_o     = cur.flags;
    assign accum_high_byte_o  = cur.accum;
    assign accum_we_o         = cur.accum_we;
    assign push_data_o        = cur.push_data;
    assign push_size_o        = cur.push_size;
    assign push_valid_o       = cur.push_valid;
    assign op_done_o          = cur.done;
    assign op_fault_o         = cur.fault;
    assign irq_take_o         = cur.irq_take;
    assign source_index_reg_o = src_val;
    assign dest_index_reg_o   = dst_val;
endmodule
`default_nettype wire

// ===== bench/flgctl_stack_model.sv
// stack side model that keeps pushed images and feeds pops
`timescale 1ns/1ps
`default_nettype none
module flgctl_stack_model
(
    input  wire logic        clk_sys_i,
    input  wire logic        push_valid_i,
    input  wire logic [63:0] push_data_i,
    input  wire logic        pop_i,
    output logic      [63:0] pop_data_o
);
    logic [63:0] mem [8];
    logic [63:0] last = 64'h0;
    int          sp = 0;
    // bench places a value on top of the stack between edges
    task put(input logic [63:0] v);
        mem[sp] = v;
        sp++;
    endtask
    // empty stack shows the inverse of the last value, never stale data
    assign pop_data_o = (sp > 0) ? mem[sp-1] : ~last;
    // take pushed images, drop the top on each pop that has no push in the same cycle
    always @(posedge clk_sys_i)
    begin
        if (push_valid_i)
        begin
            mem[sp] <= push_data_i;
            sp      <= sp + 1;
        end
        else if (pop_i && sp > 0)
        begin
            last <= mem[sp-1];
            sp   <= sp - 1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/flgctl_top_asserts.sv
// concurrent checks on the flags register block ports
`timescale 1ns/1ps
`default_nettype none
module flgctl_top_asserts
    import flgctl_pkg::*;
#(
    parameter int unsigned IDX_WIDTH = IDX_W
)
(
    input wire logic                 clk_sys_i,
    input wire logic                 rst_n_i,
    input wire logic                 op_valid_i,
    input wire logic [3:0]           op_code_i,
    input wire logic [7:0]           accum_high_byte_i,
    input wire logic                 mode64_i,
    input wire logic                 flags_to_accum_op_feature_i,
    input wire logic                 idx_load_i,
    input wire logic [3:0]           elem_size_i,
    input wire logic [1:0]           current_privilege_level_i,
    input wire logic                 maskable_irq_pin_i,
    input wire logic [31:0]          flags_word32_o,
    input wire logic [7:0]           accum_high_byte_o,
    input wire logic                 accum_we_o,
    input wire logic [63:0]          push_data_o,
    input wire logic [1:0]           push_size_o,
    input wire logic                 op_fault_o,
    input wire logic                 irq_take_o,
    input wire logic [IDX_WIDTH-1:0] source_index_reg_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // one request step and its refused answer
    sequence s_req(logic [3:0] c);
        op_valid_i && op_code_i == c;
    endsequence
    sequence s_refused;
        op_fault_o && $stable(flags_word32_o);
    endsequence
    property p_carry_inv;
        s_req(4'h3) |=> flags_word32_o == ($past(flags_word32_o) ^ 32'h1);
    endproperty
    property p_to_accum;
        s_req(4'h6) ##0 (!mode64_i || flags_to_accum_op_feature_i) |=> accum_we_o
            && accum_high_byte_o == (($past(flags_word32_o[7:0]) & 8'hd5)
            | ($past(accum_high_byte_i) & ACCUM_KEEP)) && $stable(flags_word32_o);
    endproperty
    property p_acc_fault;
        op_valid_i && op_code_i[3:1] == 3'h3 && mode64_i && !flags_to_accum_op_feature_i
            |=> s_refused ##0 !accum_we_o;
    endproperty
    property p_push_dword;
        s_req(4'h9) |=> push_data_o == {32'h0, $past(flags_word32_o)
            & ~PUSH_CLR_MASK} && push_size_o == ($past(mode64_i) ? 2'h2 : 2'h1);
    endproperty
    property p_pop_word;
        s_req(4'ha) |=> ((flags_word32_o ^ $past(flags_word32_o))
            & ~(POP_WORD_MASK | IO_PRIVILEGE_LEVEL_MASK | IE_MASK)) == 32'h0;
    endproperty
    property p_io_privilege_level_keep;
        op_valid_i && op_code_i[3:1] == 3'h5 && current_privilege_level_i != 2'h0
            |=> $stable(flags_word32_o[13:12]);
    endproperty
    property p_ie_keep;
        op_valid_i && op_code_i[3:1] == 3'h5
            && flags_word32_o[13:12] < current_privilege_level_i
            |=> $stable(flags_word32_o[9]);
    endproperty
    property p_ie_fault;
        op_valid_i && op_code_i[3:1] == 3'h6
            && flags_word32_o[13:12] < current_privilege_level_i |=> s_refused;
    endproperty
    property p_irq;
        maskable_irq_pin_i || flags_word32_o[9]
            |=> irq_take_o == $past(maskable_irq_pin_i && flags_word32_o[9]);
    endproperty
    property p_step;
        s_req(4'he) ##0 !idx_load_i |=> source_index_reg_o == ($past(
            flags_word32_o[10]) ? $past(source_index_reg_o) - $past(elem_size_i)
            : $past(source_index_reg_o) + $past(elem_size_i));
    endproperty
    a_carry_inv: assert property (p_carry_inv)
        else $error("carry invert wrong");
    a_to_accum: assert property (p_to_accum)
        else $error("flags to accum wrong");
    a_acc_fault: assert property (p_acc_fault)
        else $error("accum op not refused");
    a_push_dword: assert property (p_push_dword)
        else $error("dword push image wrong");
    a_pop_word: assert property (p_pop_word)
        else $error("word pop touched masked bits");
    a_io_privilege_level_keep: assert property (p_io_privilege_level_keep)
        else $error("io level changed by pop");
    a_ie_keep: assert property (p_ie_keep)
        else $error("interrupt enable changed by pop");
    a_ie_fault: assert property (p_ie_fault)
        else $error("interrupt enable op not refused");
    a_irq: assert property (p_irq)
        else $error("interrupt pass wrong");
    a_step: assert property (p_step)
        else $error("index step wrong");
endmodule
`default_nettype wire

// ===== bench/flgctl_top_bench.sv
// self-checking bench for the flags register block
`timescale 1ns/1ps
`default_nettype none
module flgctl_top_bench;
    import flgctl_pkg::*;
    localparam int unsigned IDX_WIDTH = IDX_W;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        op_valid_i = 1'b0;
    logic [3:0]  op_code_i = 4'h0;
    logic [7:0]  accum_high_byte_i = 8'h00;
    logic [63:0] pop_data_i;
    logic [1:0]  current_privilege_level_i = 2'h0;
    logic        mode64_i = 1'b0;
    logic        v86_mode_i = 1'b0;
    logic        flags_to_accum_op_feature_i = 1'b0;
    logic [3:0]  elem_size_i = 4'h4;
    logic        idx_load_i = 1'b0;
    logic [31:0] src_load_i = 32'h0;
    logic [31:0] dst_load_i = 32'h0;
    logic        maskable_irq_pin_i = 1'b0;
    logic [31:0] flags_word32_o, source_index_reg_o, dest_index_reg_o;
    logic [7:0]  accum_high_byte_o;
    logic [63:0] push_data_o;
    logic [1:0]  push_size_o;
    logic        accum_we_o, push_valid_o, op_done_o, op_fault_o, irq_take_o;
    int          fail_count = 0;
    int          total_checks = 0;
    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    flgctl_top uut (.*);
    flgctl_stack_model stk (
        .clk_sys_i    (clk_sys_i),
        .push_valid_i (push_valid_o),
        .push_data_i  (push_data_o),
        .pop_i        (op_valid_i && op_code_i[3:1] == 3'h5),
        .pop_data_o   (pop_data_i)
    );
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one operation, m is {feature, 64-bit mode}; answer settled on return
    task op(input logic [3:0] c, input logic [1:0] pl = 2'h0,
            input logic [1:0] m = 2'h0, input logic [7:0] a = 8'h00);
        @(posedge clk_sys_i);
        op_valid_i                <= 1'b1;
        op_code_i                 <= c;
        current_privilege_level_i <= pl;
        {flags_to_accum_op_feature_i, mode64_i} <= m;
        accum_high_byte_i         <= a;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b0;
        #1;
    endtask
    // verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (2000) @(posedge clk_sys_i);
        fail_count++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        op(4'h1);
        chk(flags_word32_o, 32'h3);
        chk(32'(op_done_o), 32'h1);
        op(4'h3);
        chk(flags_word32_o, 32'h2);
        op(4'h2);
        chk(flags_word32_o, 32'h2);
        op(4'hf);
        chk(32'(op_fault_o), 32'h1);
        chk(flags_word32_o, 32'h2);
        $display("test carry done");
        @(posedge clk_sys_i);
        idx_load_i <= 1'b1;
        src_load_i <= 32'h100;
        dst_load_i <= 32'h200;
        @(posedge clk_sys_i);
        idx_load_i <= 1'b0;
        op(4'he);
        chk(source_index_reg_o, 32'h104);
        op(4'h4);
        chk(flags_word32_o, 32'h402);
        op(4'he);
        chk(dest_index_reg_o, 32'h200);
        op(4'h5);
        chk(flags_word32_o, 32'h2);
        $display("test direction done");
        op(4'h7, 2'h0, 2'h0, 8'hd5);
        chk(flags_word32_o, 32'hd7);
        op(4'h6, 2'h0, 2'h0, 8'h2a);
        chk(32'(accum_high_byte_o), 32'hff);
        chk(32'(accum_we_o), 32'h1);
        chk(flags_word32_o, 32'hd7);
        op(4'h6, 2'h0, 2'h1, 8'h00);
        chk(32'({op_fault_o, accum_we_o}), 32'h2);
        op(4'h7, 2'h0, 2'h1, 8'h00);
        chk(32'(op_fault_o), 32'h1);
        op(4'h7, 2'h0, 2'h3, 8'h00);
        chk(flags_word32_o, 32'h2);
        $display("test accumulator done");
        stk.put(64'h0027_3fff);
        op(4'hb);
        chk(flags_word32_o, 32'h0024_3fd7);
        op(4'h8);
        chk(32'(push_data_o[15:0]), 32'h3fd7);
        chk(32'(push_size_o), 32'h0);
        chk(32'(push_valid_o), 32'h1);
        op(4'h9);
        chk(push_data_o[31:0], 32'h0024_3fd7);
        chk(32'(push_size_o), 32'h1);
        op(4'hb);
        chk(flags_word32_o, 32'h0024_3fd7);
        op(4'ha, 2'h3);
        stk.put(64'h0);
        op(4'ha, 2'h3);
        chk(flags_word32_o, 32'h0024_3002);
        stk.put(64'h0);
        op(4'ha);
        chk(flags_word32_o, 32'h0024_0002);
        stk.put(64'h200);
        op(4'hb, 2'h3);
        chk(flags_word32_o, 32'h2);
        op(4'hc, 2'h3);
        chk(32'(op_fault_o), 32'h1);
        op(4'hc);
        chk(flags_word32_o, 32'h202);
        op(4'hd, 2'h3);
        chk(32'(op_fault_o), 32'h1);
        chk(flags_word32_o, 32'h202);
        $display("test stack done");
        stk.put(64'hffff_ffff_0000_0a02);
        op(4'hb, 2'h0, 2'h1);
        chk(flags_word32_o, 32'ha02);
        op(4'h9, 2'h0, 2'h1);
        chk(push_data_o[63:32], 32'h0);
        chk(32'(push_size_o), 32'h2);
        chk(32'(push_valid_o), 32'h1);
        $display("test wide mode done");
        @(posedge clk_sys_i);
        maskable_irq_pin_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(32'(irq_take_o), 32'h1);
        op(4'hd);
        @(posedge clk_sys_i);
        #1;
        chk(32'(irq_take_o), 32'h0);
        $display("test interrupt done");
        // reset in mid-run, then a first operation right after release
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        chk(flags_word32_o, FLAGS_RESET);
        chk(source_index_reg_o, 32'h0);
        op(4'h1);
        chk(flags_word32_o, 32'h3);
        $display("test reset done");
        report_and_stop();
    end
endmodule
bind flgctl_top flgctl_top_asserts #(.IDX_WIDTH(IDX_WIDTH)) u_asrt (.*);
`default_nettype wire
